// ---- design/lsc_top.sv ----
// line supervision control: registers, debounce and automatic line state
// Behaviour
// - control bit 6 set makes the common-mode voltage follow its value.
// - control bit 5 set makes the differential voltage follow on-hook value.
// - control bit 4 enables automatic speed-up when set, disables it clear.
// - control bit 3 on the battery variant switches to low battery off-hook in an active state.
// - control bit 2 moves the line from ringing to active on a debounced ring trip.
// - control bit 1 moves the line to active on a debounced loop closure.
// - control bit 0 forces the line open on a power alarm.
// - status bit 2 shows the raw detector, 0 while the threshold is exceeded.
// - status bit 1 reads 1 once a debounced ring trip has occurred.
// - status bit 0 reads 1 once a debounced loop closure has occurred.
// - a 7-bit loop-closure interval sets steady time in 1.25 ms steps.
// - a 7-bit ring-trip interval sets steady time in 1.25 ms steps.
// - a 3-bit code selects feed current from 20 mA up in 3 mA steps.
// - unused upper bits of these registers read as zero.
// - automatic moves change the actual state, never the requested one.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lsc_top
    import lsc_pkg::*;
#(
    parameter int TICK_CYCLES     = LSC_TICK_CYC,
    parameter bit BATTERY_VARIANT = 1'b1
)(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog side
    input  wire logic        raw_detect_level,
    input  wire logic        power_alarm,
    // linefeed controls
    output logic             common_mode_manual,
    output logic             differential_manual,
    output logic             speedup_enable,
    output logic             low_battery_select,
    output logic      [2:0]  feed_current_code,
    output logic      [2:0]  actual_line_state,
    // interrupt
    output logic             irq
);

    // ********************************************************
    // declarations
    // ********************************************************
    lsc_ctrl_s   ctrl_r;
    logic [6:0]  lcdb_r;
    logic [6:0]  rtdb_r;
    logic [2:0]  requested_line_state_r;
    logic [2:0]  irq_st_r;
    logic [2:0]  irq_msk_r;
    logic [1:0]  raw_sync_r;
    logic [1:0]  alarm_sync_r;
    logic        raw_r;
    logic        raw_d_r;
    logic        alarm_d_r;
    logic [15:0] tick_cnt_r;
    logic        tick_r;
    logic [6:0]  db_cnt_r [2];
    logic [1:0]  flt_r;
    logic [1:0]  flt_d_r;
    logic [6:0]  ival [2];
    logic [7:0]  idx;
    logic        setup;
    logic        access;
    logic        wr_acc;
    logic        mapped;
    logic        alarm_rise;
    logic        rt_rise;
    logic        lc_rise;
    logic [2:0]  irq_evt;
    logic [2:0]  rd_clr_r;
    logic [31:0] rd_nxt;

    // ********************************************************
    // apb decode
    // ********************************************************
    // one zero-wait access: data are prepared in the setup cycle
    assign idx    = paddr[9:2];
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr_acc = access & pwrite & ~pslverr;
    assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00)
                    && (idx >= LSC_IDX_AUTO) && (idx <= LSC_IDX_IRQMSK);

    // read mux
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            LSC_IDX_AUTO:   rd_nxt[6:0] = ctrl_r;
            LSC_IDX_STATUS: rd_nxt[2:0] = {raw_r, flt_r[1], flt_r[0]};
            LSC_IDX_LCDB:   rd_nxt[6:0] = lcdb_r;
            LSC_IDX_RTDB:   rd_nxt[6:0] = rtdb_r;
            LSC_IDX_FEED_CURRENT_CODE:   rd_nxt[2:0] = feed_current_code;
            LSC_IDX_LINE:   rd_nxt[6:0] = {actual_line_state, 1'b0,
                                           requested_line_state_r};
            LSC_IDX_IRQST:  rd_nxt[2:0] = irq_st_r;
            LSC_IDX_IRQMSK: rd_nxt[2:0] = irq_msk_r;
            default:        rd_nxt = 32'h0000_0000;
        endcase
    end

    // answer registers, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            rd_clr_r <= 3'h0;
        end
        else
        begin
            pready   <= setup;
            pslverr  <= setup & ~mapped;
            prdata   <= (setup & ~pwrite & mapped) ? rd_nxt : 32'h0000_0000;
            // only bits actually returned get cleared
            rd_clr_r <= (setup & ~pwrite & mapped & (idx == LSC_IDX_IRQST))
                        ? irq_st_r : 3'h0;
        end
    end

    // ********************************************************
    // software registers
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r            <= LSC_RST_AUTO;
            lcdb_r            <= LSC_RST_LCDB;
            rtdb_r            <= LSC_RST_RTDB;
            feed_current_code <= LSC_RST_FEED_CURRENT_CODE;
            irq_msk_r         <= LSC_RST_MASK;
        end
        else if (wr_acc)
        begin
            if (idx == LSC_IDX_AUTO)
                ctrl_r <= pwdata[6:0];
            if (idx == LSC_IDX_LCDB)
                lcdb_r <= pwdata[6:0];
            if (idx == LSC_IDX_RTDB)
                rtdb_r <= pwdata[6:0];
            if (idx == LSC_IDX_FEED_CURRENT_CODE)
                feed_current_code <= pwdata[2:0];
            if (idx == LSC_IDX_IRQMSK)
                irq_msk_r <= pwdata[2:0];
        end
    end

    // mode outputs mirror the control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            common_mode_manual  <= 1'b0;
            differential_manual <= 1'b0;
            speedup_enable      <= 1'b0;
        end
        else
        begin
            common_mode_manual  <= ctrl_r.common_mode_manual;
            differential_manual <= ctrl_r.differential_manual;
            speedup_enable      <= ctrl_r.speedup_enable;
        end
    end

    // low battery only on the selecting variant, off-hook in an active state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_battery_select <= 1'b0;
        else
            low_battery_select <= BATTERY_VARIANT
                & ctrl_r.battery_auto_switch & flt_r[0]
                & ((actual_line_state == LSC_LS_FWD_ACT)
                   | (actual_line_state == LSC_LS_REV_ACT));
    end

    // ********************************************************
    // input synchronisers and tick
    // ********************************************************
    // raw idles high (threshold not exceeded), giving status 0x04
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_sync_r   <= 2'b11;
            alarm_sync_r <= 2'b00;
            raw_d_r      <= 1'b1;
            alarm_d_r    <= 1'b0;
        end
        else
        begin
            raw_sync_r   <= {raw_sync_r[0], raw_detect_level};
            alarm_sync_r <= {alarm_sync_r[0], power_alarm};
            raw_d_r      <= raw_r;
            alarm_d_r    <= alarm_sync_r[1];
        end
    end
    assign raw_r      = raw_sync_r[1];
    assign alarm_rise = alarm_sync_r[1] & ~alarm_d_r;

    // 1.25 ms tick divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r == 16'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // ********************************************************
    // debounce, channel 0 loop closure, channel 1 ring trip
    // ********************************************************
    assign ival[0] = lcdb_r;
    assign ival[1] = rtdb_r;

    for (genvar g = 0; g < 2; g++)
    begin : g_db
        // tick granularity: first step may be short by up to one tick
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                db_cnt_r[g] <= 7'h00;
                flt_r[g]    <= 1'b0;
            end
            else if (raw_r != raw_d_r)
                db_cnt_r[g] <= 7'h00;
            else if (flt_r[g] != ~raw_r)
            begin
                // filtered result moves after steady time
                if (db_cnt_r[g] >= ival[g])
                begin
                    flt_r[g]    <= ~raw_r;
                    db_cnt_r[g] <= 7'h00;
                end
                else if (tick_r && db_cnt_r[g] != 7'h7F)
                    db_cnt_r[g] <= db_cnt_r[g] + 7'h01;
            end
            else
                db_cnt_r[g] <= 7'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flt_d_r <= 2'b00;
        else
            flt_d_r <= flt_r;
    end
    assign lc_rise = flt_r[0] & ~flt_d_r[0];
    assign rt_rise = flt_r[1] & ~flt_d_r[1];

    // ********************************************************
    // linefeed state
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            requested_line_state_r <= LSC_LS_OPEN;
        else if (wr_acc && idx == LSC_IDX_LINE)
            requested_line_state_r <= pwdata[2:0];
    end

    // alarm outranks detections, detections outrank a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            actual_line_state <= LSC_LS_OPEN;
        else if (ctrl_r.power_alarm_auto_open && alarm_rise)
            actual_line_state <= LSC_LS_OPEN;
        else if (ctrl_r.ring_trip_auto_active && rt_rise
                 && actual_line_state == LSC_LS_RINGING)
            actual_line_state <= LSC_LS_FWD_ACT;
        else if (ctrl_r.loop_closure_auto_active && lc_rise
                 && actual_line_state != LSC_LS_REV_ACT)
            actual_line_state <= LSC_LS_FWD_ACT;
        else if (wr_acc && idx == LSC_IDX_LINE)
            actual_line_state <= pwdata[2:0];
    end

    // ********************************************************
    // interrupts
    // ********************************************************
    assign irq_evt[LSC_IRQ_PALARM] = alarm_rise;
    assign irq_evt[LSC_IRQ_RT]     = rt_rise;
    assign irq_evt[LSC_IRQ_LC]     = lc_rise;

    // a new event beats the read clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_st_r <= 3'h0;
        else
            irq_st_r <= (irq_st_r & ~(access ? rd_clr_r : 3'h0)) | irq_evt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_st_r & irq_msk_r);
    end

    // ********************************************************
    // assertions
    // ********************************************************
    sequence s_wr_auto;
        wr_acc && idx == LSC_IDX_AUTO;
    endsequence

    // a misaligned or out-of-range address answers 0, so it is left out
    sequence s_rd_status;
        setup && !pwrite && mapped && idx == LSC_IDX_STATUS;
    endsequence

    AST_CM_FOLLOW: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_auto |-> ##2 common_mode_manual == $past(pwdata[6], 2))
        else $error("common mode select not applied");

    AST_DIF_FOLLOW: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_auto |-> ##2 differential_manual == $past(pwdata[5], 2))
        else $error("differential select not applied");

    AST_SPEEDUP: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_auto ##1 (!wr_acc)[*2] |-> speedup_enable == $past(pwdata[4], 2))
        else $error("speed-up enable wrong");

    AST_BAT_OFF: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ctrl_r.battery_auto_switch |=> !low_battery_select)
        else $error("low battery without auto switch");

    AST_RT_ACTIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_r.ring_trip_auto_active && rt_rise && !alarm_rise
        && actual_line_state == LSC_LS_RINGING
        |=> actual_line_state == LSC_LS_FWD_ACT)
        else $error("ring trip did not activate line");

    AST_LC_ACTIVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_r.loop_closure_auto_active && lc_rise && !alarm_rise
        && actual_line_state == LSC_LS_OPEN
        |=> actual_line_state == LSC_LS_FWD_ACT)
        else $error("loop closure did not activate line");

    AST_ALARM_OPEN: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_r.power_alarm_auto_open && $rose(alarm_sync_r[1])
        |=> actual_line_state == LSC_LS_OPEN)
        else $error("power alarm did not open line");

    AST_RAW_VIEW: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_status |=> prdata[LSC_ST_RAW] == $past(raw_r))
        else $error("raw detect bit wrong");

    AST_UPPER_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_status |=> prdata[31:3] == 29'h0)
        else $error("status upper bits not zero");

    AST_REQ_KEPT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr_acc && idx == LSC_IDX_LINE) |=> $stable(requested_line_state_r))
        else $error("requested state changed without write");

    AST_DB_RESTART: assert property (
        @(posedge pclk) disable iff (!presetn)
        raw_r != raw_d_r |=> db_cnt_r[0] == 7'h00 && $stable(flt_r[0]))
        else $error("debounce did not restart");

endmodule
`default_nettype wire

// ---- pkg/lsc_pkg.sv ----
// constants and carriers of the line supervision control block
package lsc_pkg;

    // ********************************************************
    // register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [7:0] LSC_IDX_AUTO   = 8'h43;
    localparam logic [7:0] LSC_IDX_STATUS = 8'h44;
    localparam logic [7:0] LSC_IDX_LCDB   = 8'h45;
    localparam logic [7:0] LSC_IDX_RTDB   = 8'h46;
    localparam logic [7:0] LSC_IDX_FEED_CURRENT_CODE   = 8'h47;
    localparam logic [7:0] LSC_IDX_LINE   = 8'h48;
    localparam logic [7:0] LSC_IDX_IRQST  = 8'h49;
    localparam logic [7:0] LSC_IDX_IRQMSK = 8'h4A;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [6:0] LSC_RST_AUTO = 7'h00;
    localparam logic [6:0] LSC_RST_LCDB = 7'h0A;
    localparam logic [6:0] LSC_RST_RTDB = 7'h0A;
    localparam logic [2:0] LSC_RST_FEED_CURRENT_CODE = 3'h0;
    localparam logic [2:0] LSC_RST_MASK = 3'h0;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int LSC_ST_RAW     = 2;
    localparam int LSC_ST_RT      = 1;
    localparam int LSC_ST_LC      = 0;
    localparam int LSC_LINE_ACT   = 4;
    localparam int LSC_IRQ_PALARM = 2;
    localparam int LSC_IRQ_RT     = 1;
    localparam int LSC_IRQ_LC     = 0;

    // ********************************************************
    // linefeed state codes
    // ********************************************************
    localparam logic [2:0] LSC_LS_OPEN    = 3'h0;
    localparam logic [2:0] LSC_LS_FWD_ACT = 3'h1;
    localparam logic [2:0] LSC_LS_RINGING = 3'h4;
    localparam logic [2:0] LSC_LS_REV_ACT = 3'h5;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int LSC_CLK_NS  = 50;
    localparam int LSC_TICK_NS = 1_250_000;
    localparam int LSC_TICK_CYC = LSC_TICK_NS / LSC_CLK_NS;

    // automatic/manual control fields
    typedef struct packed {
        logic common_mode_manual;
        logic differential_manual;
        logic speedup_enable;
        logic battery_auto_switch;
        logic ring_trip_auto_active;
        logic loop_closure_auto_active;
        logic power_alarm_auto_open;
    } lsc_ctrl_s;

endpackage

// ---- verif/lsc_line_model.sv ----
// model of the subscriber line as seen through the linefeed detector
`timescale 1ns/1ns
`default_nettype none
module lsc_line_model (
    // clock
    input  wire logic       pclk,
    // scenario controls
    input  wire logic       off_hook,
    input  wire logic       alarm,
    input  wire logic [7:0] bounce_len,
    // detector outputs
    output logic            raw_detect_level,
    output logic            power_alarm
);
    logic [7:0] left_r = 8'h00;
    logic       last_r = 1'b0;

    // ********************************************************
    // hook contact with bounce
    // ********************************************************
    // a hook change chatters for bounce_len cycles before it settles;
    // zero gives a clean edge, so one model serves prompt and slow lines
    always @(posedge pclk)
    begin
        if (off_hook != last_r)
            left_r <= bounce_len;
        else if (left_r != 8'h00)
            left_r <= left_r - 8'h01;
        last_r <= off_hook;
        if (left_r > 8'h01)
            raw_detect_level <= ~raw_detect_level;
        else
            raw_detect_level <= ~off_hook; // low while loop is closed
    end

    // alarm follows its command; the block syncs it
    always @(posedge pclk)
        power_alarm <= alarm;

    initial raw_detect_level = 1'b1;
    initial power_alarm = 1'b0;
endmodule
`default_nettype wire

// ---- verif/lsc_top_tb.sv ----
// self-checking bench of the line supervision control block
`timescale 1ns/1ns
`default_nettype none
module lsc_top_tb import lsc_pkg::*;;
    localparam int TICKS  = 10; // short tick keeps the run brief
    localparam int BOUNCE = 40;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, v;
    logic        raw_detect_level, power_alarm, off_hook, alarm_cmd;
    logic        common_mode_manual, differential_manual, speedup_enable;
    logic        low_battery_select, irq, rerr;
    logic [2:0]  feed_current_code, actual_line_state;
    int          fails, samples_checked, seed, k;
    logic [7:0]  ridx [4] = '{LSC_IDX_AUTO, LSC_IDX_LCDB, LSC_IDX_RTDB,
                              LSC_IDX_FEED_CURRENT_CODE};
    logic [31:0] rmsk [4] = '{32'h0000_007F, 32'h0000_007F, 32'h0000_007F,
                              32'h0000_0007};
    logic [7:0]  rc [5] = '{8'h00, 8'h04, 8'h0A, 8'h00, 8'h0A};
    logic [2:0]  rs [5] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h5};
    logic [2:0]  re [5] = '{3'h4, 3'h1, 3'h1, 3'h0, 3'h5};

    lsc_top #(.TICK_CYCLES(TICKS), .BATTERY_VARIANT(1'b1)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .raw_detect_level(raw_detect_level), .power_alarm(power_alarm),
        .common_mode_manual(common_mode_manual),
        .differential_manual(differential_manual),
        .speedup_enable(speedup_enable),
        .low_battery_select(low_battery_select),
        .feed_current_code(feed_current_code),
        .actual_line_state(actual_line_state), .irq(irq));

    lsc_line_model line (
        .pclk(pclk), .off_hook(off_hook), .alarm(alarm_cmd),
        .bounce_len(8'(BOUNCE)), .raw_detect_level(raw_detect_level),
        .power_alarm(power_alarm));

    always #25 pclk = ~pclk;

    // ********************************************************
    // helpers
    // ********************************************************
    // low battery only while the line sits in an active state
    function automatic logic exp_lb(input logic [7:0] c, input logic [2:0] s);
        return c[3] && (s == LSC_LS_FWD_ACT || s == LSC_LS_REV_ACT);
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fails++;
            summarize();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(rdat, exp);
    endtask

    // poll the filtered flags, bounded
    task automatic wait_flags(input logic [1:0] exp);
        int i;
        for (i = 0; i < 80; i++)
        begin
            apb(1'b0, LSC_IDX_STATUS, 32'h0000_0000);
            if (rdat[1:0] === exp)
                break;
        end
        if (i >= 80)
        begin
            fails++;
            summarize();
        end
    endtask

    // on-hook, set start state and mode, go off-hook with bounce
    task automatic hook(input logic [7:0] c, input logic [2:0] st,
                        input logic [2:0] exp);
        off_hook <= 1'b0;
        wait_flags(2'b00);
        apb(1'b1, LSC_IDX_LINE, {29'h0, st});
        apb(1'b1, LSC_IDX_AUTO, {24'h0, c});
        off_hook <= 1'b1;
        repeat (BOUNCE + 12) @(posedge pclk);
        rd(LSC_IDX_STATUS, 32'h0000_0000);
        wait_flags(2'b01);
        wait_flags(2'b11);
        repeat (4) @(posedge pclk);
        rd(LSC_IDX_STATUS, 32'h0000_0003);
        rd(LSC_IDX_LINE, {25'h0, exp, 1'b0, st});
        chk(low_battery_select, exp_lb(c, exp));
        $display("hook test ctrl %h done", c);
    endtask

    task automatic alarm(input logic [2:0] exp);
        alarm_cmd <= 1'b1;
        repeat (4) @(posedge pclk);
        alarm_cmd <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(actual_line_state, exp);
    endtask

    // ********************************************************
    // main sequence
    // ********************************************************
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, off_hook, alarm_cmd} = 5'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        seed = 32'h5a1d_fc81;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(LSC_IDX_AUTO, 32'h0000_0000);
        rd(LSC_IDX_STATUS, 32'h0000_0004);
        rd(LSC_IDX_LCDB, 32'h0000_000A);
        rd(LSC_IDX_RTDB, 32'h0000_000A);
        rd(LSC_IDX_FEED_CURRENT_CODE, 32'h0000_0000);
        rd(LSC_IDX_IRQMSK, 32'h0000_0000);
        chk(irq, 1'b0);
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            v = $random(seed);
            k = i % 4;
            apb(1'b1, ridx[k], v);
            rd(ridx[k], v & rmsk[k]);
            if (k == 0)
            begin
                chk(common_mode_manual, v[6]);
                chk(differential_manual, v[5]);
                chk(speedup_enable, v[4]);
            end
            if (k == 3)
                chk(feed_current_code, v[2:0]);
        end
        $display("register test done");
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        chk(rerr, 1'b1);
        apb(1'b1, 8'h4B, 32'h0000_00FF);
        chk(rerr, 1'b1);
        apb(1'b1, LSC_IDX_LCDB, 32'h0000_0004);
        // longer ring-trip interval: loop closure must settle first
        apb(1'b1, LSC_IDX_RTDB, 32'h0000_0008);
        apb(1'b1, LSC_IDX_IRQMSK, 32'h0000_0003);
        for (int i = 0; i < 5; i++)
            hook(rc[i], rs[i], re[i]);
        chk(irq, 1'b1);
        rd(LSC_IDX_IRQST, 32'h0000_0003);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        rd(LSC_IDX_IRQST, 32'h0000_0000);
        alarm(LSC_LS_REV_ACT);
        chk(irq, 1'b0);
        apb(1'b1, LSC_IDX_AUTO, 32'h0000_000B);
        alarm(LSC_LS_OPEN);
        chk(low_battery_select, 1'b0);
        apb(1'b1, LSC_IDX_IRQMSK, 32'h0000_0007);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        rd(LSC_IDX_IRQST, 32'h0000_0004);
        $display("alarm and interrupt test done");
        summarize();
    end
endmodule
`default_nettype wire
